//--- cpu_core_execution_timing.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Four stages per instruction, sixteen-bit ALU.
// - Plain instructions take one instruction cycle of four clocks.
// - Shifts and rotates use a barrel shifter, one cycle any amount.
// - A taken branch that misses the jump cache costs two instruction cycles.
// - Sixteen by sixteen multiply takes five instruction cycles.
// - Thirty-two by sixteen divide takes ten instruction cycles.
// - Jump cache hit on a repeated jump costs one cycle.
// - Sixteen general registers live in internal RAM.
// - Register RAM address is context base plus register offset.
// - Any base, banks may overlap; addresses wrap in RAM.
// - Stack pointer addresses a 2048-byte stack in RAM.
// - Pushes and traps check the upper limit, pops check the lower limit.
// - Two operands go to the coprocessor per instruction cycle.
// - Coprocessor holds multiply-accumulate and repeat units.
// - Conditional jumps are four bytes, taken only if condition holds.
// - Two-byte trap jumps to vector from its immediate number.
// - Power-down enters power-down; outside holds NMI pin low.
// - Init-done instruction changes the reset output pin.
// - Compare register with immediate, then step register by one or two.
// - Normalise-count writes shift count of one register to another.
// - Jump-clear-bit jumps if bit set and clears it.
// - Byte-to-word move replicates the sign bit upward.
// - Coprocessor instructions use a four-byte encoding.
module cpu_core_execution_timing (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Code fetch
  output logic      [15:0] code_addr,
  input  wire logic [31:0] code_data,
  // Internal RAM, word addressed
  output logic      [9:0]  ram_addr,
  output logic      [15:0] ram_wdata,
  output logic             ram_we,
  input  wire logic [15:0] ram_rdata,
  // Coprocessor operands
  output logic             mac_valid,
  output logic      [15:0] mac_cmd,
  output logic      [15:0] mac_op1,
  output logic      [15:0] mac_op2,
  // System pins
  input  wire logic        nmi_n,
  output logic             reset_output_pin,
  output logic             power_down,
  output logic             stack_trap,
  output logic             instr_retired
);
  typedef enum logic [1:0] {PH_FETCH, PH_DECODE, PH_OPERAND, PH_EXECUTE} phase_type;
  typedef enum logic [2:0] {K_ONE, K_HIT, K_MISS, K_MUL, K_DIV} kind_type;

  function automatic logic [9:0] reg_word(input logic [10:0] base, input logic [3:0] r);
    logic [10:0] byte_addr;
    byte_addr = base + {6'h00, r, 1'b0};
    return byte_addr[10:1];
  endfunction

  function automatic logic cond_true(input logic [3:0] cc, input logic fz, fc, fn);
    logic t;
    t = 1'b0;
    case (cc)
      4'h0: t = 1'b1;
      4'h1: t = fz;
      4'h2: t = !fz;
      4'h3: t = fc;
      4'h4: t = !fc;
      4'h5: t = fn;
      4'h6: t = !fn;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic [15:0] normalize_count_op_count(input logic [15:0] v);
    logic [15:0] cnt;
    logic        seen;
    cnt = 16'h0000;
    seen = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i])
        seen = 1'b1;
      else if (!seen && v != 16'h0000)
        cnt = cnt + 16'h0001;
    end
    return cnt;
  endfunction

  phase_type   ph;
  phase_type   next_ph;
  logic [31:0] ir;
  logic [15:0] a_val;
  logic [15:0] md_hi;
  logic [10:0] context_base_reg;
  logic [10:0] stack_ptr_reg;
  logic [10:0] stack_upper_limit;
  logic [10:0] stack_lower_limit;
  logic        fz, fc, fn;
  logic [3:0]  stall;
  logic        jc_valid;
  logic [15:0] jc_pc;
  logic        nmi_meta, nmi_sync;

  // Decode fields of the latched instruction
  wire [7:0]  op = ir[31:24];
  wire [3:0]  ra = ir[23:20];
  wire [3:0]  rb = ir[19:16];
  wire [15:0] imm = ir[15:0];
  wire [15:0] b_val = ram_rdata;
  wire        fire = (ph == PH_EXECUTE) && (stall == 4'h0) && !power_down;
  wire [15:0] len = op[7] ? cpu_core_pkg::LEN_LONG : cpu_core_pkg::LEN_SHORT;
  wire [15:0] seq_pc = code_addr + len;
  wire [15:0] rel_pc = seq_pc + imm;
  wire [15:0] trap_pc = {6'h00, ir[23:16], 2'b00};
  wire [10:0] sp_dec = stack_ptr_reg - 11'h002;
  wire [10:0] sp_inc = stack_ptr_reg + 11'h002;
  wire        push_fault = sp_dec < stack_upper_limit;
  wire        pop_fault = stack_ptr_reg >= stack_lower_limit;
  wire [16:0] sum = {1'b0, a_val} + {1'b0, b_val};
  wire [16:0] dif = {1'b0, a_val} - {1'b0, b_val};
  wire [16:0] cmp = {1'b0, a_val} - {1'b0, imm};
  wire [15:0] step = (op == cpu_core_pkg::OP_CMPI2 || op == cpu_core_pkg::OP_CMPD2) ?
                     16'h0002 : 16'h0001;
  // Barrel shifter: all amounts in one pass
  wire [3:0]  sh = b_val[3:0];
  wire [31:0] dbl = {a_val, a_val};
  wire [31:0] dbl_l = dbl << sh;
  wire [31:0] dbl_r = dbl >> sh;
  wire [31:0] prod = {16'h0000, a_val} * {16'h0000, b_val};
  wire [31:0] dividend = {md_hi, a_val};
  wire        div_zero = b_val == 16'h0000;
  // Divide by zero saturates rather than leaving the result undefined
  wire [31:0] quo = div_zero ? 32'hFFFFFFFF : dividend / {16'h0000, b_val};
  wire [31:0] rem = div_zero ? dividend : dividend % {16'h0000, b_val};
  wire        jc_hit = jc_valid && (jc_pc == code_addr);

  logic [15:0] next_pc, wr_data, res;
  logic [9:0]  wr_addr;
  logic        wr_en, flag_en, c_out, trap_hit, jc_load, sfr_en;
  logic [3:0]  next_stall;
  logic [10:0] next_sp;
  kind_type    kind;

  always_comb begin
    next_pc = seq_pc;
    res = a_val;
    c_out = fc;
    wr_en = 1'b0;
    wr_addr = reg_word(context_base_reg, ra);
    flag_en = 1'b0;
    next_stall = 4'h0;
    next_sp = stack_ptr_reg;
    trap_hit = 1'b0;
    jc_load = 1'b0;
    sfr_en = 1'b0;
    kind = K_ONE;
    unique case (op)
      cpu_core_pkg::OP_ADD: {c_out, res} = sum;
      cpu_core_pkg::OP_SUB: {c_out, res} = dif;
      cpu_core_pkg::OP_AND: res = a_val & b_val;
      cpu_core_pkg::OP_OR: res = a_val | b_val;
      cpu_core_pkg::OP_XOR: res = a_val ^ b_val;
      cpu_core_pkg::OP_SHL: res = a_val << sh;
      cpu_core_pkg::OP_SHR: res = a_val >> sh;
      cpu_core_pkg::OP_ROL: res = dbl_l[31:16];
      cpu_core_pkg::OP_ROR: res = dbl_r[15:0];
      cpu_core_pkg::OP_ASHR: res = $signed(a_val) >>> sh;
      cpu_core_pkg::OP_MUL: begin
        res = prod[15:0];
        next_stall = cpu_core_pkg::MUL_STALL;
        kind = K_MUL;
      end
      cpu_core_pkg::OP_DIV: begin
        res = quo[15:0];
        next_stall = cpu_core_pkg::DIV_STALL;
        kind = K_DIV;
      end
      cpu_core_pkg::OP_NORMALIZE_COUNT_OP: res = normalize_count_op_count(b_val);
      cpu_core_pkg::OP_MOV_SEXT: res = {{8{b_val[7]}}, b_val[7:0]};
      cpu_core_pkg::OP_MOVI: res = imm;
      cpu_core_pkg::OP_CMPI1, cpu_core_pkg::OP_CMPI2: begin
        {c_out, res} = cmp;
        wr_en = 1'b1;
      end
      cpu_core_pkg::OP_CMPD1, cpu_core_pkg::OP_CMPD2: begin
        {c_out, res} = cmp;
        wr_en = 1'b1;
      end
      cpu_core_pkg::OP_PUSH: begin
        res = a_val;
        wr_addr = sp_dec[10:1];
        trap_hit = push_fault;
        next_sp = sp_dec;
      end
      cpu_core_pkg::OP_POP: begin
        res = b_val;
        trap_hit = pop_fault;
        next_sp = sp_inc;
      end
      cpu_core_pkg::OP_TRAP: begin
        res = seq_pc;
        wr_addr = sp_dec[10:1];
        trap_hit = push_fault;
        next_sp = sp_dec;
        next_pc = trap_pc;
      end
      cpu_core_pkg::OP_JMPC: begin
        if (cond_true(ra, fz, fc, fn)) begin
          next_pc = imm;
          jc_load = !jc_hit;
          next_stall = jc_hit ? 4'h0 : cpu_core_pkg::BRANCH_STALL;
          kind = jc_hit ? K_HIT : K_MISS;
        end
      end
      cpu_core_pkg::OP_JUMP_CLR: begin
        res = a_val & ~(16'h0001 << rb);
        if (a_val[rb]) begin
          next_pc = rel_pc;
          next_stall = cpu_core_pkg::BRANCH_STALL;
          kind = K_MISS;
        end
      end
      cpu_core_pkg::OP_LDSFR: sfr_en = 1'b1;
      cpu_core_pkg::OP_NOP, cpu_core_pkg::OP_POWER_DOWN, cpu_core_pkg::OP_INIT_DONE,
      cpu_core_pkg::OP_COP: res = a_val;
      default: res = a_val;
    endcase
    if (op inside {cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_AND,
                   cpu_core_pkg::OP_OR, cpu_core_pkg::OP_XOR, cpu_core_pkg::OP_SHL,
                   cpu_core_pkg::OP_SHR, cpu_core_pkg::OP_ROL, cpu_core_pkg::OP_ROR,
                   cpu_core_pkg::OP_ASHR, cpu_core_pkg::OP_CMPI1, cpu_core_pkg::OP_CMPI2,
                   cpu_core_pkg::OP_CMPD1, cpu_core_pkg::OP_CMPD2})
      flag_en = 1'b1;
    if (op inside {cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_AND,
                   cpu_core_pkg::OP_OR, cpu_core_pkg::OP_XOR, cpu_core_pkg::OP_SHL,
                   cpu_core_pkg::OP_SHR, cpu_core_pkg::OP_ROL, cpu_core_pkg::OP_ROR,
                   cpu_core_pkg::OP_ASHR, cpu_core_pkg::OP_MUL, cpu_core_pkg::OP_DIV,
                   cpu_core_pkg::OP_NORMALIZE_COUNT_OP, cpu_core_pkg::OP_MOV_SEXT, cpu_core_pkg::OP_MOVI,
                   cpu_core_pkg::OP_PUSH, cpu_core_pkg::OP_POP, cpu_core_pkg::OP_TRAP,
                   cpu_core_pkg::OP_JUMP_CLR})
      wr_en = 1'b1;
    // Faulting stack access is dropped before it touches RAM
    if (trap_hit) begin
      wr_en = 1'b0;
      next_sp = stack_ptr_reg;
      next_pc = cpu_core_pkg::STACK_TRAP_VEC;
    end
  end

  // Compare-and-step writes the stepped register, not the difference
  wire        cmp_op = op inside {cpu_core_pkg::OP_CMPI1, cpu_core_pkg::OP_CMPI2,
                                  cpu_core_pkg::OP_CMPD1, cpu_core_pkg::OP_CMPD2};
  wire [15:0] stepped = op[2] ? a_val - step : a_val + step;
  assign wr_data = cmp_op ? stepped : res;

  // Four stages, one per clock; execute is the instruction-cycle enable
  always_comb begin
    unique case (ph)
      PH_FETCH: next_ph = PH_DECODE;
      PH_DECODE: next_ph = PH_OPERAND;
      PH_OPERAND: next_ph = PH_EXECUTE;
      PH_EXECUTE: next_ph = PH_FETCH;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_meta <= 1'b1;
      nmi_sync <= 1'b1;
      ph <= PH_FETCH;
    end else begin
      nmi_meta <= nmi_n;
      nmi_sync <= nmi_meta;
      ph <= next_ph;
    end
  end

  // Register A latched at operand; register B is taken live at execute
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ir <= 32'h00000000;
      a_val <= 16'h0000;
    end else if (ph == PH_DECODE) begin
      ir <= code_data;
    end else if (ph == PH_OPERAND) begin
      a_val <= ram_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      stall <= 4'h0;
    else if (ph == PH_EXECUTE && !power_down)
      stall <= (stall != 4'h0) ? stall - 4'h1 : next_stall;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_addr <= cpu_core_pkg::PC_RESET;
      stack_ptr_reg <= cpu_core_pkg::STACK_PTR_RESET;
      md_hi <= 16'h0000;
      {fz, fc, fn} <= 3'b000;
    end else if (fire) begin
      code_addr <= next_pc;
      stack_ptr_reg <= sfr_en && ra[1:0] == 2'h1 ? imm[10:0] : next_sp;
      if (op == cpu_core_pkg::OP_MUL)
        md_hi <= prod[31:16];
      else if (op == cpu_core_pkg::OP_DIV)
        md_hi <= rem[15:0];
      if (flag_en)
        {fz, fc, fn} <= {res == 16'h0000, c_out, res[15]};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      context_base_reg <= cpu_core_pkg::CTX_BASE_RESET;
      stack_upper_limit <= cpu_core_pkg::STK_UP_RESET;
      stack_lower_limit <= cpu_core_pkg::STK_LO_RESET;
      jc_valid <= 1'b0;
      jc_pc <= 16'h0000;
      power_down <= 1'b0;
      reset_output_pin <= 1'b0;
    end else if (fire) begin
      if (sfr_en && ra[1:0] == 2'h0)
        context_base_reg <= imm[10:0];
      if (sfr_en && ra[1:0] == 2'h2)
        stack_upper_limit <= imm[10:0];
      if (sfr_en && ra[1:0] == 2'h3)
        stack_lower_limit <= imm[10:0];
      if (jc_load) begin
        jc_valid <= 1'b1;
        jc_pc <= code_addr;
      end
      // Entry only while the pin is held low from outside
      if (op == cpu_core_pkg::OP_POWER_DOWN && !nmi_sync)
        power_down <= 1'b1;
      if (op == cpu_core_pkg::OP_INIT_DONE)
        reset_output_pin <= 1'b1;
    end
  end

  // RAM reads lag the address by a clock, so addresses lead by one stage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_addr <= 10'h000;
      ram_wdata <= 16'h0000;
      ram_we <= 1'b0;
    end else begin
      ram_we <= fire && wr_en;
      if (ph == PH_FETCH)
        ram_addr <= reg_word(context_base_reg, code_data[23:20]);
      else if (ph == PH_DECODE)
        ram_addr <= (code_data[31:24] == cpu_core_pkg::OP_POP) ? stack_ptr_reg[10:1] :
                    reg_word(context_base_reg, code_data[19:16]);
      else if (fire) begin
        ram_addr <= wr_addr;
        ram_wdata <= wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mac_valid <= 1'b0;
      mac_cmd <= 16'h0000;
      mac_op1 <= 16'h0000;
      mac_op2 <= 16'h0000;
      stack_trap <= 1'b0;
      instr_retired <= 1'b0;
    end else begin
      mac_valid <= fire && op == cpu_core_pkg::OP_COP;
      stack_trap <= fire && trap_hit;
      instr_retired <= fire;
      if (fire && op == cpu_core_pkg::OP_COP) begin
        mac_cmd <= imm;
        mac_op1 <= a_val;
        mac_op2 <= b_val;
      end
    end
  end

  // Assertion helpers: clocks between executes and what caused the gap
  logic [7:0] gap;
  kind_type   last_kind;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 8'h00;
      last_kind <= K_ONE;
    end else if (fire) begin
      gap <= 8'h00;
      last_kind <= kind;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end

  sequence trap_taken;
    stack_trap && !ram_we ##0 code_addr == cpu_core_pkg::STACK_TRAP_VEC;
  endsequence

  chk_stage_walk: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire |-> $past(ph, 3) == PH_FETCH)
    else $error("execute not preceded by three stages");
  chk_one_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && last_kind == K_ONE && !$past(power_down) |-> gap == 8'h03)
    else $error("single-cycle instruction gap wrong");
  chk_branch_two: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && last_kind == K_MISS |-> gap == 8'h07)
    else $error("taken branch not two cycles");
  chk_cache_hit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && last_kind == K_HIT |-> gap == 8'h03)
    else $error("cached jump not one cycle");
  chk_mul_five: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && last_kind == K_MUL |-> gap == 8'h13)
    else $error("multiply not five cycles");
  chk_div_ten: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && last_kind == K_DIV |-> gap == 8'h27)
    else $error("divide not ten cycles");
  chk_gpr_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ph == PH_DECODE |-> ram_addr == reg_word(context_base_reg, code_data[23:20]))
    else $error("register address not base plus offset");
  chk_stack_limit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && op == cpu_core_pkg::OP_PUSH && push_fault |=> trap_taken)
    else $error("stack overflow not trapped");
  chk_pc_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && op == cpu_core_pkg::OP_MOVI |=> code_addr == $past(code_addr) + 16'h0004)
    else $error("pc did not advance by length");
  chk_init_pin: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && op == cpu_core_pkg::OP_INIT_DONE |=> reset_output_pin)
    else $error("reset output pin unchanged");
  chk_mac_ops: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && op == cpu_core_pkg::OP_COP |=> mac_valid && mac_op2 == $past(ram_rdata))
    else $error("coprocessor operands not delivered");
endmodule
`default_nettype wire

//--- cpu_core_pkg.sv
package cpu_core_pkg;
  // Timing, in picoseconds so the rounding stays integer
  localparam int CLK_PS = 8000;
  localparam int INSTR_PS = 31250;
  localparam int INSTR_CLKS = (INSTR_PS + CLK_PS - 1) / CLK_PS;
  localparam int MUL_CYCLES = 5;
  localparam int DIV_CYCLES = 10;
  localparam int BRANCH_CYCLES = 2;
  localparam int GPR_COUNT = 16;
  localparam int STACK_BYTES = 2048;
  localparam int RAM_AW = $clog2(STACK_BYTES);
  localparam logic [3:0] MUL_STALL = 4'(MUL_CYCLES - 1);
  localparam logic [3:0] DIV_STALL = 4'(DIV_CYCLES - 1);
  localparam logic [3:0] BRANCH_STALL = 4'(BRANCH_CYCLES - 1);
  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [10:0] CTX_BASE_RESET = 11'h000;
  localparam logic [10:0] STACK_PTR_RESET = 11'h7FE;
  localparam logic [10:0] STK_UP_RESET = 11'h000;
  localparam logic [10:0] STK_LO_RESET = 11'h7FE;
  localparam logic [15:0] STACK_TRAP_VEC = 16'h0008;
  localparam logic [15:0] LEN_SHORT = 16'h0002;
  localparam logic [15:0] LEN_LONG = 16'h0004;
  // Opcodes; bit 7 set marks a four-byte encoding
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_ADD = 8'h01;
  localparam logic [7:0] OP_SUB = 8'h02;
  localparam logic [7:0] OP_AND = 8'h03;
  localparam logic [7:0] OP_OR = 8'h04;
  localparam logic [7:0] OP_XOR = 8'h05;
  localparam logic [7:0] OP_SHL = 8'h06;
  localparam logic [7:0] OP_SHR = 8'h07;
  localparam logic [7:0] OP_ROL = 8'h08;
  localparam logic [7:0] OP_ROR = 8'h09;
  localparam logic [7:0] OP_ASHR = 8'h0A;
  localparam logic [7:0] OP_MUL = 8'h0B;
  localparam logic [7:0] OP_DIV = 8'h0C;
  localparam logic [7:0] OP_PUSH = 8'h0D;
  localparam logic [7:0] OP_POP = 8'h0E;
  localparam logic [7:0] OP_NORMALIZE_COUNT_OP = 8'h0F;
  localparam logic [7:0] OP_TRAP = 8'h10;
  localparam logic [7:0] OP_MOV_SEXT = 8'h11;
  localparam logic [7:0] OP_JMPC = 8'h80;
  localparam logic [7:0] OP_JUMP_CLR = 8'h81;
  localparam logic [7:0] OP_CMPI1 = 8'h82;
  localparam logic [7:0] OP_CMPI2 = 8'h83;
  localparam logic [7:0] OP_CMPD1 = 8'h84;
  localparam logic [7:0] OP_CMPD2 = 8'h85;
  localparam logic [7:0] OP_MOVI = 8'h86;
  localparam logic [7:0] OP_LDSFR = 8'h87;
  localparam logic [7:0] OP_POWER_DOWN = 8'h88;
  localparam logic [7:0] OP_INIT_DONE = 8'h89;
  localparam logic [7:0] OP_COP = 8'h8A;
endpackage

//--- internal_ram_area_model.sv
`timescale 1ns/1ps
`default_nettype none
module internal_ram_area_model (
  // Clock
  input  wire logic        ref_clk,
  // Word-addressed port
  input  wire logic [9:0]  ram_addr,
  input  wire logic [15:0] ram_wdata,
  input  wire logic        ram_we,
  output logic      [15:0] ram_rdata
);
  logic [15:0] mem [0:1023];

  // Plain always so the bench may clear the array between runs
  always @(posedge ref_clk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    ram_rdata <= mem[ram_addr];
  end
endmodule
`default_nettype wire

//--- cpu_core_execution_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_execution_timing_test;
  localparam int IC = cpu_core_pkg::INSTR_CLKS;
  logic        ref_clk;
  logic        reset_n;
  logic        nmi_n;
  logic [15:0] code_addr;
  logic [9:0]  ram_addr;
  logic [15:0] ram_wdata;
  logic [15:0] ram_rdata;
  logic [15:0] mac_cmd;
  logic [15:0] mac_op1;
  logic [15:0] mac_op2;
  logic        ram_we;
  logic        mac_valid;
  logic        reset_output_pin;
  logic        power_down;
  logic        stack_trap;
  logic        instr_retired;
  logic [31:0] rom [0:255];
  int          error_cnt;
  int          cmp_count;
  int          cyc;
  int          rt[$];
  wire  [31:0] code_data = rom[code_addr[8:1]];

  cpu_core_execution_timing cpu_core_execution_timing_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .code_addr(code_addr), .code_data(code_data),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata),
    .mac_valid(mac_valid), .mac_cmd(mac_cmd), .mac_op1(mac_op1), .mac_op2(mac_op2),
    .nmi_n(nmi_n), .reset_output_pin(reset_output_pin), .power_down(power_down),
    .stack_trap(stack_trap), .instr_retired(instr_retired));
  internal_ram_area_model internal_ram_area_model_i (.ref_clk(ref_clk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_rdata(ram_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Retire times, sampled mid-cycle where outputs are settled
  always @(negedge ref_clk) begin
    cyc++;
    if (instr_retired === 1'b1) rt.push_back(cyc);
  end

  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] op, input logic [3:0] ra,
                     input logic [3:0] rb, input logic [15:0] imm);
    rom[a[8:1]] = {op, ra, rb, imm};
  endtask

  task automatic hold();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    nmi_n <= 1'b1;
    foreach (rom[i]) rom[i] = 32'h0;
    for (int i = 0; i < 1024; i++) internal_ram_area_model_i.mem[i] = 16'h0;
  endtask

  task automatic go();
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rt.delete();
  endtask

  task automatic wait_ret(input int k);
    for (int i = 0; i < 400 && rt.size() < k; i++) @(negedge ref_clk);
    if (rt.size() < k) begin
      error_cnt++;
      $display("CHECK FAILED retire count expected %0d seen %0d", k, rt.size());
      test_done();
    end
    @(negedge ref_clk);
  endtask

  task automatic wait_on(input int s);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 400 && !h; i++) begin
      @(negedge ref_clk);
      h = (s == 0) ? stack_trap === 1'b1 : (s == 1) ? mac_valid === 1'b1 : power_down === 1'b1;
    end
    if (!h) begin
      error_cnt++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", s);
      test_done();
    end
  endtask

  task automatic t_arith();
    hold();
    put(16'h0, cpu_core_pkg::OP_MOVI, 4'h1, 4'h0, 16'h0007);
    put(16'h4, cpu_core_pkg::OP_MOVI, 4'h2, 4'h0, 16'h0003);
    put(16'h8, cpu_core_pkg::OP_MUL, 4'h1, 4'h2, 16'h0);
    put(16'hA, cpu_core_pkg::OP_DIV, 4'h1, 4'h2, 16'h0);
    put(16'hC, cpu_core_pkg::OP_ADD, 4'h1, 4'h2, 16'h0);
    go();
    wait_ret(5);
    chk("plain time", 16'(IC), 16'(rt[1] - rt[0]));
    chk("mul div time", 16'(IC * 16), 16'(rt[4] - rt[1]));
    chk("r1 result", 16'h000A, internal_ram_area_model_i.mem[1]);
    chk("r2 value", 16'h0003, internal_ram_area_model_i.mem[2]);
    $display("test arith done");
  endtask

  task automatic t_bank();
    hold();
    put(16'h0, cpu_core_pkg::OP_LDSFR, 4'h0, 4'h0, 16'h0100);
    put(16'h4, cpu_core_pkg::OP_MOVI, 4'h3, 4'h0, 16'hBEEF);
    put(16'h8, cpu_core_pkg::OP_LDSFR, 4'h0, 4'h0, 16'h0104);
    put(16'hC, cpu_core_pkg::OP_MOVI, 4'h1, 4'h0, 16'h1234);
    go();
    wait_ret(4);
    chk("shared word", 16'h1234, internal_ram_area_model_i.mem[10'h083]);
    chk("bank zero r3", 16'h0000, internal_ram_area_model_i.mem[3]);
    $display("test bank done");
  endtask

  task automatic t_jump();
    hold();
    put(16'h0, cpu_core_pkg::OP_MOVI, 4'h1, 4'h0, 16'h8001);
    put(16'h4, cpu_core_pkg::OP_MOVI, 4'h2, 4'h0, 16'h000F);
    put(16'h8, cpu_core_pkg::OP_ROL, 4'h1, 4'h2, 16'h0);
    put(16'hA, cpu_core_pkg::OP_JMPC, 4'h8, 4'h0, 16'h0000);
    put(16'hE, cpu_core_pkg::OP_JMPC, 4'h0, 4'h0, 16'h000E);
    go();
    wait_ret(8);
    chk("rotate time", 16'(IC), 16'(rt[2] - rt[1]));
    chk("not taken", 16'(IC), 16'(rt[3] - rt[2]));
    chk("miss then hits", 16'(IC * 4), 16'(rt[6] - rt[3]));
    chk("hit time", 16'(IC), 16'(rt[7] - rt[6]));
    chk("rotate value", 16'hC000, internal_ram_area_model_i.mem[1]);
    $display("test jump done");
  endtask

  task automatic t_stack();
    hold();
    put(16'h0, cpu_core_pkg::OP_MOVI, 4'h1, 4'h0, 16'h55AA);
    put(16'h4, cpu_core_pkg::OP_LDSFR, 4'h2, 4'h0, 16'h07FC);
    put(16'h8, cpu_core_pkg::OP_PUSH, 4'h1, 4'h1, 16'h0);
    put(16'hA, cpu_core_pkg::OP_PUSH, 4'h1, 4'h1, 16'h0);
    go();
    wait_on(0);
    chk("trap target", 16'h0008, code_addr);
    @(negedge ref_clk);
    chk("trap pulse", 16'h0, 16'(stack_trap));
    chk("pushed word", 16'h55AA, internal_ram_area_model_i.mem[10'h3FE]);
    chk("no fault write", 16'h0000, internal_ram_area_model_i.mem[10'h3FD]);
    $display("test stack done");
  endtask

  task automatic t_misc();
    hold();
    put(16'h0, cpu_core_pkg::OP_INIT_DONE, 4'h0, 4'h0, 16'h0);
    put(16'h4, cpu_core_pkg::OP_MOVI, 4'h1, 4'h0, 16'h1111);
    put(16'h8, cpu_core_pkg::OP_MOVI, 4'h2, 4'h0, 16'h2222);
    put(16'hC, cpu_core_pkg::OP_COP, 4'h1, 4'h2, 16'hABCD);
    put(16'h10, cpu_core_pkg::OP_TRAP, 4'h0, 4'h8, 16'h0);
    put(16'h20, cpu_core_pkg::OP_POWER_DOWN, 4'h0, 4'h0, 16'h0);
    go();
    @(negedge ref_clk);
    chk("pin at reset", 16'h0, 16'(reset_output_pin));
    wait_on(1);
    chk("operand one", 16'h1111, mac_op1);
    chk("operand two", 16'h2222, mac_op2);
    chk("cop command", 16'hABCD, mac_cmd);
    chk("init pin", 16'h1, 16'(reset_output_pin));
    @(posedge ref_clk);
    nmi_n <= 1'b0;
    wait_on(2);
    chk("return pc", 16'h0012, internal_ram_area_model_i.mem[10'h3FE]);
    $display("test misc done");
  endtask

  task automatic t_ops();
    hold();
    put(16'h0, cpu_core_pkg::OP_MOVI, 4'h1, 4'h0, 16'h0080);
    put(16'h4, cpu_core_pkg::OP_MOV_SEXT, 4'h2, 4'h1, 16'h0);
    put(16'h6, cpu_core_pkg::OP_NORMALIZE_COUNT_OP, 4'h3, 4'h1, 16'h0);
    put(16'h8, cpu_core_pkg::OP_CMPI2, 4'h1, 4'h0, 16'h0000);
    put(16'hC, cpu_core_pkg::OP_JUMP_CLR, 4'h1, 4'h1, 16'h0010);
    put(16'h10, cpu_core_pkg::OP_MOVI, 4'h4, 4'h0, 16'h1111);
    put(16'h20, cpu_core_pkg::OP_MOVI, 4'h5, 4'h0, 16'h5555);
    go();
    wait_ret(6);
    chk("sign extend", 16'hFF80, internal_ram_area_model_i.mem[2]);
    chk("normalise count", 16'h0008, internal_ram_area_model_i.mem[3]);
    chk("step then clear", 16'h0080, internal_ram_area_model_i.mem[1]);
    chk("skipped word", 16'h0000, internal_ram_area_model_i.mem[4]);
    chk("jump target", 16'h5555, internal_ram_area_model_i.mem[5]);
    chk("bit jump time", 16'(IC * 2), 16'(rt[5] - rt[4]));
    $display("test ops done");
  endtask

  initial begin
    reset_n = 1'b0;
    nmi_n = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    foreach (rom[i]) rom[i] = 32'h0;
    t_arith();
    t_bank();
    t_jump();
    t_stack();
    t_misc();
    t_ops();
    test_done();
  end
endmodule
`default_nettype wire
